// ===== design/csp_classify.sv
// sorts one character code into its syntactic classes
`timescale 1ns/1ps
module csp_classify (
  // code under test
  input  wire logic [7:0] code,
  // classes
  output logic            is_ctl,
  output logic            is_esc,
  output logic            is_abort,
  output logic            is_xon,
  output logic            is_xoff,
  output logic            is_inter,
  output logic            is_param,
  output logic            is_priv_param,
  output logic            is_esc_final,
  output logic            is_esc_std_fin,
  output logic            is_csi_final,
  output logic            is_csi_priv_fin,
  output logic            is_csi_2nd
);
  assign is_ctl          = (code <= csp_pkg::CODE_CTL_MAX) || (code == csp_pkg::CODE_DEL);
  assign is_esc          = (code == csp_pkg::CODE_ESC);
  assign is_abort        = (code == csp_pkg::CODE_CAN) || (code == csp_pkg::CODE_SUB);
  assign is_xon          = (code == csp_pkg::CODE_XON);
  assign is_xoff         = (code == csp_pkg::CODE_XOFF);
  assign is_inter        = (code >= csp_pkg::INTER_LO) && (code <= csp_pkg::INTER_HI);
  assign is_param        = (code >= csp_pkg::PARAM_LO) && (code <= csp_pkg::PARAM_HI);
  assign is_priv_param   = (code >= csp_pkg::PRIV_PARAM_LO) && (code <= csp_pkg::PARAM_HI);
  assign is_esc_final    = (code >= csp_pkg::ESC_FINAL_LO) && (code <= csp_pkg::FINAL_HI);
  assign is_esc_std_fin  = (code >= csp_pkg::ESC_STD_FIN_LO) && (code <= csp_pkg::FINAL_HI);
  assign is_csi_final    = (code >= csp_pkg::CSI_FINAL_LO) && (code <= csp_pkg::FINAL_HI);
  assign is_csi_priv_fin = (code >= csp_pkg::CSI_PRIV_FIN) && (code <= csp_pkg::FINAL_HI);
  assign is_csi_2nd      = (code == csp_pkg::CODE_CSI_2ND);
endmodule : csp_classify

// ===== design/csp_fifo.sv
// character FIFO with registered full and empty
`timescale 1ns/1ps
module csp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= (next_count != CW'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

endmodule : csp_fifo

// ===== design/csp_parser.sv
// control sequence parser: classifies a received character stream
`timescale 1ns/1ps
module csp_parser #(
  parameter int FIFO_DEPTH = csp_pkg::FIFO_DEPTH,
  parameter int PARAM_MAX  = csp_pkg::PARAM_MAX,
  parameter int INTER_MAX  = csp_pkg::INTER_MAX,
  localparam int CW        = csp_pkg::CHAR_W,
  localparam int PCW       = $clog2(PARAM_MAX + 1),
  localparam int ICW       = $clog2(INTER_MAX + 1)
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // received character stream
  input  wire logic                    in_valid,
  input  wire logic [CW-1:0]           in_data,
  output logic                         in_ready,
  // mode
  input  wire logic                    std_mode,
  // event report
  input  wire logic                    ev_ready,
  output logic                         ev_valid,
  output csp_pkg::csp_kind_e           ev_kind,
  output logic [CW-1:0]                ev_code,
  output logic [PARAM_MAX*CW-1:0]      ev_params,
  output logic [PCW-1:0]               ev_param_cnt,
  output logic [INTER_MAX*CW-1:0]      ev_inters,
  output logic [ICW-1:0]               ev_inter_cnt,
  output logic                         ev_trunc,
  output logic                         ev_nonstd,
  // flow control
  output logic                         xon_pulse,
  output logic                         xoff_pulse,
  output logic                         flow_stopped
);

  ////////////////////////////////////////////////////////////////////////////
  // input buffer

  logic          q_valid;
  logic [CW-1:0] q_data;
  logic          take;

  csp_fifo #(
    .WIDTH (CW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_data   (in_data),
    .in_ready  (in_ready),
    .out_valid (q_valid),
    .out_data  (q_data),
    .out_ready (take)
  );

  // a character is consumed only when the report slot is free
  assign take = q_valid && (!ev_valid || ev_ready);

  ////////////////////////////////////////////////////////////////////////////
  // classification

  logic c_ctl;
  logic c_esc;
  logic c_abort;
  logic c_xon;
  logic c_xoff;
  logic c_inter;
  logic c_param;
  logic c_priv_param;
  logic c_esc_final;
  logic c_esc_std_fin;
  logic c_csi_final;
  logic c_csi_priv_fin;
  logic c_csi_2nd;

  csp_classify u_class (
    .code            (q_data),
    .is_ctl          (c_ctl),
    .is_esc          (c_esc),
    .is_abort        (c_abort),
    .is_xon          (c_xon),
    .is_xoff         (c_xoff),
    .is_inter        (c_inter),
    .is_param        (c_param),
    .is_priv_param   (c_priv_param),
    .is_esc_final    (c_esc_final),
    .is_esc_std_fin  (c_esc_std_fin),
    .is_csi_final    (c_csi_final),
    .is_csi_priv_fin (c_csi_priv_fin),
    .is_csi_2nd      (c_csi_2nd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decisions for the character being consumed

  csp_pkg::csp_state_e     state;
  logic [PARAM_MAX*CW-1:0] p_buf;
  logic [PCW-1:0]          p_cnt;
  logic [INTER_MAX*CW-1:0] i_buf;
  logic [ICW-1:0]          i_cnt;
  logic                    seq_bad;
  logic                    seq_trunc;

  logic emit_ctl;
  logic emit_chr;
  logic emit_esc;
  logic emit_csi;
  logic go_ground;
  logic go_esc;
  logic go_csi;
  logic add_param;
  logic add_inter;
  logic mark_bad;
  logic fin_nonstd;

  always_comb begin
    emit_ctl   = 1'b0;
    emit_chr   = 1'b0;
    emit_esc   = 1'b0;
    emit_csi   = 1'b0;
    go_ground  = 1'b0;
    go_esc     = 1'b0;
    go_csi     = 1'b0;
    add_param  = 1'b0;
    add_inter  = 1'b0;
    mark_bad   = 1'b0;
    fin_nonstd = 1'b0;
    if (take) begin
      // escape restarts, cancel and substitute abort, other controls act in place
      if (c_esc) begin
        go_esc = 1'b1;
      end else if (c_abort && state != csp_pkg::ST_GROUND) begin
        emit_ctl  = 1'b1;
        go_ground = 1'b1;
      end else if (c_ctl) begin
        emit_ctl = 1'b1;
      end else begin
        case (state)
          csp_pkg::ST_GROUND: begin
            emit_chr = 1'b1;
          end
          csp_pkg::ST_ESC: begin
            if (c_inter) begin
              add_inter = 1'b1;
            end else if (c_csi_2nd && i_cnt == '0) begin
              go_csi = 1'b1;
            end else if (c_esc_final) begin
              emit_esc   = 1'b1;
              fin_nonstd = !c_esc_std_fin;
              go_ground  = 1'b1;
            end else begin
              go_ground = 1'b1;
            end
          end
          csp_pkg::ST_CSI: begin
            if (c_param) begin
              add_param = 1'b1;
              mark_bad  = c_priv_param || (i_cnt != '0);
            end else if (c_inter) begin
              add_inter = 1'b1;
            end else if (c_csi_final) begin
              emit_csi   = 1'b1;
              fin_nonstd = c_csi_priv_fin;
              go_ground  = 1'b1;
            end else begin
              go_ground = 1'b1;
            end
          end
          default: begin
            go_ground = 1'b1;
          end
        endcase
      end
    end
  end

  logic seq_nonstd;
  logic seq_drop;

  assign seq_nonstd = seq_bad || seq_trunc || fin_nonstd;
  assign seq_drop   = std_mode && seq_nonstd;

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= csp_pkg::ST_GROUND;
    end else if (go_esc) begin
      state <= csp_pkg::ST_ESC;
    end else if (go_csi) begin
      state <= csp_pkg::ST_CSI;
    end else if (go_ground) begin
      state <= csp_pkg::ST_GROUND;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // collection of parameters and intermediates

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p_buf     <= '0;
      p_cnt     <= '0;
      i_buf     <= '0;
      i_cnt     <= '0;
      seq_bad   <= 1'b0;
      seq_trunc <= 1'b0;
    end else if (go_esc || go_ground) begin
      p_buf     <= '0;
      p_cnt     <= '0;
      i_buf     <= '0;
      i_cnt     <= '0;
      seq_bad   <= 1'b0;
      seq_trunc <= 1'b0;
    end else begin
      if (mark_bad) begin
        seq_bad <= 1'b1;
      end
      if (add_param) begin
        if (p_cnt == PCW'(PARAM_MAX)) begin
          seq_trunc <= 1'b1;
        end else begin
          p_buf[p_cnt*CW +: CW] <= q_data;
          p_cnt                 <= p_cnt + PCW'(1);
        end
      end
      if (add_inter) begin
        if (i_cnt == ICW'(INTER_MAX)) begin
          seq_trunc <= 1'b1;
        end else begin
          i_buf[i_cnt*CW +: CW] <= q_data;
          i_cnt                 <= i_cnt + ICW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event report, held until accepted

  logic emit_seq;

  assign emit_seq = (emit_esc || emit_csi) && !seq_drop;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev_valid     <= 1'b0;
      ev_kind      <= csp_pkg::KIND_CHAR;
      ev_code      <= '0;
      ev_params    <= '0;
      ev_param_cnt <= '0;
      ev_inters    <= '0;
      ev_inter_cnt <= '0;
      ev_trunc     <= 1'b0;
      ev_nonstd    <= 1'b0;
    end else if (emit_ctl || emit_chr || emit_seq) begin
      ev_valid     <= 1'b1;
      ev_code      <= q_data;
      ev_params    <= emit_seq ? p_buf : '0;
      ev_param_cnt <= emit_seq ? p_cnt : '0;
      ev_inters    <= emit_seq ? i_buf : '0;
      ev_inter_cnt <= emit_seq ? i_cnt : '0;
      ev_trunc     <= emit_seq && seq_trunc;
      ev_nonstd    <= emit_seq && seq_nonstd;
      if (emit_ctl) begin
        ev_kind <= csp_pkg::KIND_CTL;
      end else if (emit_chr) begin
        ev_kind <= csp_pkg::KIND_CHAR;
      end else if (emit_esc) begin
        ev_kind <= csp_pkg::KIND_ESC;
      end else begin
        ev_kind <= csp_pkg::KIND_CSI;
      end
    end else if (ev_ready) begin
      ev_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flow control codes

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xon_pulse    <= 1'b0;
      xoff_pulse   <= 1'b0;
      flow_stopped <= 1'b0;
    end else begin
      xon_pulse  <= emit_ctl && c_xon;
      xoff_pulse <= emit_ctl && c_xoff;
      if (emit_ctl && c_xoff) begin
        flow_stopped <= 1'b1;
      end else if (emit_ctl && c_xon) begin
        flow_stopped <= 1'b0;
      end
    end
  end

endmodule : csp_parser

// ===== inc/csp_pkg.sv
// constants and types shared by the control sequence parser
package csp_pkg;

  // character codes
  localparam logic [7:0] CODE_CTL_MAX   = 8'h1F;
  localparam logic [7:0] CODE_DEL       = 8'h7F;
  localparam logic [7:0] CODE_ESC       = 8'h1B;
  localparam logic [7:0] CODE_CSI_2ND   = 8'h5B;
  localparam logic [7:0] CODE_XON       = 8'h11;
  localparam logic [7:0] CODE_XOFF      = 8'h13;
  localparam logic [7:0] CODE_CAN       = 8'h18;
  localparam logic [7:0] CODE_SUB       = 8'h1A;

  // character class ranges
  localparam logic [7:0] INTER_LO       = 8'h20;
  localparam logic [7:0] INTER_HI       = 8'h2F;
  localparam logic [7:0] PARAM_LO       = 8'h30;
  localparam logic [7:0] PARAM_HI       = 8'h3F;
  localparam logic [7:0] PRIV_PARAM_LO  = 8'h3C;
  localparam logic [7:0] ESC_FINAL_LO   = 8'h30;
  localparam logic [7:0] CSI_FINAL_LO   = 8'h40;
  localparam logic [7:0] FINAL_HI       = 8'h7E;
  localparam logic [7:0] ESC_STD_FIN_LO = 8'h40;
  localparam logic [7:0] CSI_PRIV_FIN   = 8'h70;

  // sizes
  localparam int FIFO_DEPTH = 8;
  localparam int CHAR_W     = 8;
  localparam int PARAM_MAX  = 8;
  localparam int INTER_MAX  = 2;

  // parser states
  typedef enum logic [2:0] {
    ST_GROUND = 3'b001,
    ST_ESC    = 3'b010,
    ST_CSI    = 3'b100
  } csp_state_e;

  // kind of reported event
  typedef enum logic [1:0] {
    KIND_CHAR = 2'h0,
    KIND_CTL  = 2'h1,
    KIND_ESC  = 2'h2,
    KIND_CSI  = 2'h3
  } csp_kind_e;

endpackage : csp_pkg

// ===== tb/csp_host_model.sv
// host side source that holds each character until taken
`timescale 1ns/1ps
module csp_host_model (
  // clock
  input  wire logic       clock,
  // character link
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic      [7:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data  = 8'h00;
  end
  // gap above zero is a slow host; released data is inverted, except that a slow send ends with its last character restored
  task automatic send_q(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      in_valid <= 1'b1;
      in_data  <= q[i];
      @(posedge clock);
      while (in_ready !== 1'b1) @(posedge clock);
      if (gap > 0) begin
        in_valid <= 1'b0;
        in_data  <= ~q[i];
        repeat (gap) @(posedge clock);
      end
    end
    in_valid <= 1'b0;
    in_data  <= ~in_data;
  endtask : send_q
endmodule : csp_host_model

// ===== tb/csp_parser_properties.sv
// concurrent checks on the parser ports
`timescale 1ns/1ps
module csp_parser_properties #(
  parameter int  PARAM_MAX = 8,
  parameter int  INTER_MAX = 2,
  localparam int PCW       = $clog2(PARAM_MAX + 1),
  localparam int ICW       = $clog2(INTER_MAX + 1)
) (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst_n,
  // mode and event report
  input wire logic                     std_mode,
  input wire logic                     ev_ready,
  input wire logic                     ev_valid,
  input wire csp_pkg::csp_kind_e       ev_kind,
  input wire logic [7:0]               ev_code,
  input wire logic [PARAM_MAX*8-1:0]   ev_params,
  input wire logic [PCW-1:0]           ev_param_cnt,
  input wire logic [INTER_MAX*8-1:0]   ev_inters,
  input wire logic [ICW-1:0]           ev_inter_cnt,
  input wire logic                     ev_nonstd,
  // flow control
  input wire logic                     xon_pulse,
  input wire logic                     xoff_pulse,
  input wire logic                     flow_stopped
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  chk_ev_hold: assert property (ev_valid && !ev_ready |=> ev_valid &&
    $stable(ev_code) && $stable(ev_kind) && $stable(ev_params)) else $error("event moved");
  chk_ctl_code: assert property (ev_valid && ev_kind == csp_pkg::KIND_CTL |->
    ev_code <= 8'h1F || ev_code == 8'h7F) else $error("bad control code");
  chk_esc_final: assert property (ev_valid && ev_kind == csp_pkg::KIND_ESC |->
    ev_code inside {[8'h30:8'h7E]} && ev_param_cnt == 0) else $error("bad escape final");
  chk_csi_final: assert property (ev_valid && ev_kind == csp_pkg::KIND_CSI |->
    ev_code inside {[8'h40:8'h7E]}) else $error("bad sequence final");
  chk_param_code: assert property (ev_valid && ev_param_cnt != 0 |->
    ev_params[7:0] inside {[8'h30:8'h3F]}) else $error("bad parameter");
  chk_inter_code: assert property (ev_valid && ev_inter_cnt != 0 |->
    ev_inters[7:0] inside {[8'h20:8'h2F]}) else $error("bad intermediate");
  chk_std_drop: assert property (ev_valid && std_mode |-> !ev_nonstd)
    else $error("nonstandard event in standard mode");
  chk_xon_event: assert property (xon_pulse |-> ev_valid && ev_code == 8'h11 &&
    !flow_stopped) else $error("resume pulse wrong");
  chk_xoff_event: assert property (xoff_pulse |-> ev_valid && ev_code == 8'h13 &&
    flow_stopped) else $error("stop pulse wrong");
  chk_flow_rise: assert property ($rose(flow_stopped) |-> xoff_pulse)
    else $error("stop without code");
  chk_flow_fall: assert property ($fell(flow_stopped) |-> xon_pulse)
    else $error("resume without code");
  cov_csi: cover property (ev_valid && ev_kind == csp_pkg::KIND_CSI);
  cov_esc: cover property (ev_valid && ev_kind == csp_pkg::KIND_ESC);
  cov_stall: cover property (ev_valid && !ev_ready [*3]);
endmodule : csp_parser_properties

bind csp_parser csp_parser_properties #(.PARAM_MAX(PARAM_MAX), .INTER_MAX(INTER_MAX)) u_chk (
  .clock(clock), .rst_n(rst_n), .std_mode(std_mode), .ev_ready(ev_ready),
  .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_code(ev_code), .ev_params(ev_params),
  .ev_param_cnt(ev_param_cnt), .ev_inters(ev_inters), .ev_inter_cnt(ev_inter_cnt),
  .ev_nonstd(ev_nonstd), .xon_pulse(xon_pulse), .xoff_pulse(xoff_pulse),
  .flow_stopped(flow_stopped));

// ===== tb/tb.sv
// self-checking bench for the control sequence parser
`timescale 1ns/1ps
module tb;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  logic               std_mode = 1'b0;
  logic               ev_ready = 1'b1;
  logic               in_valid, in_ready, ev_valid, ev_trunc, ev_nonstd;
  logic               xon_pulse, xoff_pulse, flow_stopped;
  logic [7:0]         in_data, ev_code;
  csp_pkg::csp_kind_e ev_kind;
  logic [63:0]        ev_params;
  logic [3:0]         ev_param_cnt;
  logic [15:0]        ev_inters;
  logic [1:0]         ev_inter_cnt;
  int                 bad_count = 0;
  int                 n_compared = 0;
  logic [40:0]        got[$];
  logic [80:0]        last_wide;

  always #20 clock = ~clock;

  csp_parser dut (.clock(clock), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .std_mode(std_mode), .ev_ready(ev_ready), .ev_valid(ev_valid),
    .ev_kind(ev_kind), .ev_code(ev_code), .ev_params(ev_params),
    .ev_param_cnt(ev_param_cnt), .ev_inters(ev_inters), .ev_inter_cnt(ev_inter_cnt),
    .ev_trunc(ev_trunc), .ev_nonstd(ev_nonstd), .xon_pulse(xon_pulse),
    .xoff_pulse(xoff_pulse), .flow_stopped(flow_stopped));
  csp_host_model u_host (.clock(clock), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data));

  always @(posedge clock) if (ev_valid === 1'b1 && ev_ready === 1'b1) begin
    last_wide = {ev_trunc, ev_params, ev_inters};
    got.push_back({ev_kind, ev_code, ev_param_cnt, ev_params[15:0], ev_inter_cnt,
      ev_inters[7:0], ev_nonstd});
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [40:0] e(logic [1:0] k, logic [7:0] c, logic [3:0] pc,
    logic [15:0] p, logic [1:0] ic, logic [7:0] i, logic ns);
    return {k, c, pc, p, ic, i, ns};
  endfunction : e

  function automatic logic [40:0] ec(logic [1:0] k, logic [7:0] c);
    return e(k, c, 4'h0, 16'h0000, 2'h0, 8'h00, 1'b0);
  endfunction : ec

  task automatic chk(input logic [80:0] seen, input logic [80:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t saw %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic pop(input logic [40:0] want);
    int n;
    n = 0;
    while (got.size() == 0 && n < 60) begin
      @(posedge clock);
      n++;
    end
    if (got.size() == 0) chk('x, want);
    else chk(got.pop_front(), want);
  endtask : pop

  task automatic t_ctl;
    u_host.send_q('{8'h00, 8'h1F, 8'h7F, 8'h20, 8'h80}, 0);
    pop(ec(csp_pkg::KIND_CTL, 8'h00));
    pop(ec(csp_pkg::KIND_CTL, 8'h1F));
    pop(ec(csp_pkg::KIND_CTL, 8'h7F));
    pop(ec(csp_pkg::KIND_CHAR, 8'h20));
    pop(ec(csp_pkg::KIND_CHAR, 8'h80));
    $display("test ctl done");
  endtask : t_ctl

  task automatic t_flow;
    u_host.send_q('{8'h13}, 0);
    pop(ec(csp_pkg::KIND_CTL, 8'h13));
    chk(flow_stopped, 1'b1);
    u_host.send_q('{8'h11}, 0);
    pop(ec(csp_pkg::KIND_CTL, 8'h11));
    chk(flow_stopped, 1'b0);
    $display("test flow done");
  endtask : t_flow

  task automatic t_esc;
    u_host.send_q('{8'h1B, 8'h30, 8'h1B, 8'h20, 8'h2F, 8'h7E, 8'h1B, 8'h41, 8'h42}, 3);
    pop(e(csp_pkg::KIND_ESC, 8'h30, 4'h0, 16'h0000, 2'h0, 8'h00, 1'b1));
    pop(e(csp_pkg::KIND_ESC, 8'h7E, 4'h0, 16'h0000, 2'h2, 8'h20, 1'b0));
    pop(ec(csp_pkg::KIND_ESC, 8'h41));
    pop(ec(csp_pkg::KIND_CHAR, 8'h42));
    $display("test esc done");
  endtask : t_esc

  task automatic t_csi;
    u_host.send_q('{8'h1B, 8'h5B, 8'h31, 8'h3B, 8'h32, 8'h6D, 8'h1B, 8'h5B, 8'h40,
      8'h1B, 8'h5B, 8'h20, 8'h7E, 8'h41}, 0);
    pop(e(csp_pkg::KIND_CSI, 8'h6D, 4'h3, 16'h3B31, 2'h0, 8'h00, 1'b0));
    pop(ec(csp_pkg::KIND_CSI, 8'h40));
    pop(e(csp_pkg::KIND_CSI, 8'h7E, 4'h0, 16'h0000, 2'h1, 8'h20, 1'b1));
    pop(ec(csp_pkg::KIND_CHAR, 8'h41));
    $display("test csi done");
  endtask : t_csi

  // controls inside a sequence, cancel, restart, high codes, truncation
  task automatic t_odd;
    u_host.send_q('{8'h1B, 8'h5B, 8'h31, 8'h0A, 8'h32, 8'h6D, 8'h1B, 8'h5B, 8'h31, 8'h18,
      8'h41, 8'h1B, 8'h20, 8'h5B, 8'h1B, 8'h5B, 8'h80, 8'h41, 8'h1B, 8'h5B, 8'h31, 8'h1B,
      8'h41}, 0);
    pop(ec(csp_pkg::KIND_CTL, 8'h0A));
    pop(e(csp_pkg::KIND_CSI, 8'h6D, 4'h2, 16'h3231, 2'h0, 8'h00, 1'b0));
    pop(ec(csp_pkg::KIND_CTL, 8'h18));
    pop(ec(csp_pkg::KIND_CHAR, 8'h41));
    pop(e(csp_pkg::KIND_ESC, 8'h5B, 4'h0, 16'h0000, 2'h1, 8'h20, 1'b0));
    pop(ec(csp_pkg::KIND_CHAR, 8'h41));
    pop(ec(csp_pkg::KIND_ESC, 8'h41));
    u_host.send_q('{8'h1B, 8'h5B, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
      8'h39, 8'h20, 8'h21, 8'h22, 8'h6D}, 0);
    pop(e(csp_pkg::KIND_CSI, 8'h6D, 4'h8, 16'h3231, 2'h2, 8'h20, 1'b1));
    chk(last_wide, {1'b1, 64'h3837363534333231, 16'h2120});
    $display("test odd done");
  endtask : t_odd

  task automatic t_std;
    std_mode <= 1'b1;
    @(posedge clock);
    u_host.send_q('{8'h1B, 8'h5B, 8'h3F, 8'h31, 8'h68, 8'h1B, 8'h5B, 8'h31, 8'h70,
      8'h1B, 8'h30, 8'h1B, 8'h5B, 8'h32, 8'h4A}, 0);
    pop(e(csp_pkg::KIND_CSI, 8'h4A, 4'h1, 16'h0032, 2'h0, 8'h00, 1'b0));
    std_mode <= 1'b0;
    $display("test std done");
  endtask : t_std

  task automatic t_stall;
    logic [7:0] q[$];
    for (int i = 0; i < 12; i++) q.push_back(8'h41 + 8'(i));
    ev_ready <= 1'b0;
    fork
      u_host.send_q(q, 0);
    join_none
    repeat (20) @(posedge clock);
    chk(in_ready, 1'b0);
    ev_ready <= 1'b1;
    for (int i = 0; i < 12; i++) pop(ec(csp_pkg::KIND_CHAR, 8'h41 + 8'(i)));
    $display("test stall done");
  endtask : t_stall

  task automatic t_rst;
    u_host.send_q('{8'h13}, 0);
    pop(ec(csp_pkg::KIND_CTL, 8'h13));
    rst_n <= 1'b0;
    @(posedge clock);
    chk({ev_valid, in_ready, flow_stopped}, 3'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    u_host.send_q('{8'h41}, 0);
    pop(ec(csp_pkg::KIND_CHAR, 8'h41));
    $display("test rst done");
  endtask : t_rst

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_ctl;
    t_flow;
    t_esc;
    t_csi;
    t_odd;
    t_std;
    t_stall;
    t_rst;
    tally_and_finish;
  end

  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
endmodule : tb
